// file: common/ple_pkg.sv
// Constants, field layouts and types shared by the programmable logic equation bank
//
// Contract
// - Four configurable selected inputs feed each gate
// - Each gate input individually invertible
// - Gate result passes on and off delay
// - Direct output plus latching held output
// - Latched output also offered inverted
// - Latch reset selectable from list, invertible
// - Set and reset together: reset wins
// - Equations evaluated ascending, cycle repeats forever
// - Any equation output selectable as input
// - Lower feeding higher uses same-scan value
// - Higher feeding lower uses previous-scan value
// - Outputs drive relays, blocking; inputs from signals
// - Inputs and outputs observable as status
package ple_pkg;

    // ******************************************************
    // Sizes of the equation bank and the signal pool
    // ******************************************************
    localparam int NUM_EQ  = 8;
    localparam int IDX_W   = 3;
    localparam int EXT_W   = 32;
    localparam int SEL_W   = 6;
    localparam int POOL_W  = 64;
    localparam int TMR_W   = 16;
    localparam int NUM_IN  = 4;

    // Pool layout: external signals, then direct, latched and inverted latched outputs
    localparam int POOL_EXT_LSB = 0;
    localparam int POOL_OUT_LSB = 32;
    localparam int POOL_LAT_LSB = 40;
    localparam int POOL_LTN_LSB = 48;

    // ******************************************************
    // Register map (byte addresses)
    // ******************************************************
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_SCAN     = 12'h004;
    localparam logic [11:0] ADDR_EQ_BASE  = 12'h100;
    localparam logic [1:0]  WORD_INPUTS   = 2'h0;
    localparam logic [1:0]  WORD_DELAYS   = 2'h1;
    localparam logic [1:0]  WORD_RESET    = 2'h2;
    localparam logic [1:0]  WORD_STATUS   = 2'h3;

    // Field positions of the input word
    localparam int IN_INV_LSB  = 24;
    localparam int IN_OP_LSB   = 28;
    // Field positions of the delay word
    localparam int DLY_ON_LSB  = 0;
    localparam int DLY_OFF_LSB = 16;
    // Field positions of the reset word
    localparam int RST_INV_BIT = 8;
    // Field positions of the status word and the control word
    localparam int ST_GATE_BIT = 4;
    localparam int ST_OUT_BIT  = 5;
    localparam int ST_LAT_BIT  = 6;
    localparam int ST_LTN_BIT  = 7;
    localparam int ST_RST_BIT  = 8;
    localparam int CTRL_EN_BIT = 0;

    // ******************************************************
    // Values after reset, and bus response codes
    // ******************************************************
    localparam logic [31:0] CFG_IN_RST  = 32'h0000_0000;
    localparam logic [31:0] CFG_DLY_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_RST_RST = 32'h0000_003f;
    localparam logic        EN_RST      = 1'b1;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // Gate operators
    typedef enum logic [2:0] {
        PLE_OP_AND  = 3'b000,
        PLE_OP_OR   = 3'b001,
        PLE_OP_NAND = 3'b010,
        PLE_OP_NOR  = 3'b011,
        PLE_OP_XOR  = 3'b100,
        PLE_OP_XNOR = 3'b101
    } ple_op_t;

endpackage : ple_pkg

// file: hw/ple_eval.sv
// Combinational evaluation of one logic equation: gate, delay timer and latch
`timescale 1ns/100ps
`default_nettype none
module ple_eval
(
    input  wire logic [ple_pkg::POOL_W-1:0] pool,
    input  wire logic [31:0]                cfg_in,
    input  wire logic [31:0]                cfg_dly,
    input  wire logic [31:0]                cfg_rst,
    input  wire logic [ple_pkg::TMR_W-1:0]  tmr,
    input  wire logic                       tout,
    input  wire logic                       latch,
    output logic      [ple_pkg::NUM_IN-1:0] in_st,
    output logic                            gate,
    output logic                            rst_act,
    output logic      [ple_pkg::TMR_W-1:0]  tmr_nxt,
    output logic                            tout_nxt,
    output logic                            latch_nxt
);
    import ple_pkg::*;

    // Pick one pool bit; indices past the pool read as zero
    function automatic logic pick(input logic [POOL_W-1:0] p, input logic [SEL_W-1:0] sel, input logic inv);
        pick = p[sel] ^ inv;
    endfunction : pick

    logic [TMR_W:0] cnt;
    logic [TMR_W:0] lim;

    always_comb
    begin
        // Selected and optionally inverted gate inputs
        for (int i = 0; i < NUM_IN; i++)
        begin
            in_st[i] = pick(pool, cfg_in[i*SEL_W +: SEL_W], cfg_in[IN_INV_LSB+i]);
        end
        // Gate operator; unused codes fall back to AND
        unique case (cfg_in[IN_OP_LSB +: 3])
            PLE_OP_OR:   gate = |in_st;
            PLE_OP_NAND: gate = ~&in_st;
            PLE_OP_NOR:  gate = ~|in_st;
            PLE_OP_XOR:  gate = ^in_st;
            PLE_OP_XNOR: gate = ~^in_st;
            default:     gate = &in_st;
        endcase
        // Timer restarts whenever the gate returns to the current output
        cnt = {1'b0, tmr} + {{TMR_W{1'b0}}, 1'b1};
        lim = {1'b0, gate ? cfg_dly[DLY_ON_LSB +: TMR_W] : cfg_dly[DLY_OFF_LSB +: TMR_W]};
        tout_nxt = tout;
        tmr_nxt  = '0;
        if (gate != tout)
        begin
            if (cnt >= lim)
            begin
                tout_nxt = gate;
            end
            else
            begin
                tmr_nxt = cnt[TMR_W-1:0];
            end
        end
        // Reset-dominant latch
        rst_act   = pick(pool, cfg_rst[SEL_W-1:0], cfg_rst[RST_INV_BIT]);
        latch_nxt = rst_act ? 1'b0 : (latch | tout_nxt);
    end

endmodule : ple_eval
`default_nettype wire

// file: hw/ple_top.sv
// Bank of programmable logic equations with an AXI4-Lite register port
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ple_top
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [11:0]                   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [11:0]                   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic [ple_pkg::EXT_W-1:0]     ext_sig,
    output logic [ple_pkg::NUM_EQ-1:0]         eq_out,
    output logic [ple_pkg::NUM_EQ-1:0]         eq_latched,
    output logic [ple_pkg::NUM_EQ-1:0]         eq_latched_n,
    output logic                               scan_done
);
    import ple_pkg::*;

    // ******************************************************
    // State
    // ******************************************************
    typedef struct packed {
        logic                          awrdy;
        logic                          aw_got;
        logic [11:0]                   aw_addr;
        logic                          wrdy;
        logic                          w_got;
        logic [31:0]                   w_data;
        logic [3:0]                    w_strb;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arrdy;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
        logic                          enable;
        logic [IDX_W-1:0]              ptr;
        logic                          scan_done;
        logic [15:0]                   scan_cnt;
        logic [NUM_EQ-1:0][31:0]       cfg_in;
        logic [NUM_EQ-1:0][31:0]       cfg_dly;
        logic [NUM_EQ-1:0][31:0]       cfg_rst;
        logic [NUM_EQ-1:0][TMR_W-1:0]  tmr;
        logic [NUM_EQ-1:0][NUM_IN-1:0] in_st;
        logic [NUM_EQ-1:0]             gate;
        logic [NUM_EQ-1:0]             rst_act;
        logic [NUM_EQ-1:0]             out;
        logic [NUM_EQ-1:0]             latch;
        logic [NUM_EQ-1:0]             latch_n;
    } ple_state_t;

    ple_state_t st_r;
    ple_state_t st_nxt;

    // Address decode: {hit, is_eq, index, word}
    function automatic logic [6:0] dec(input logic [11:0] a);
        dec = 7'h00;
        if (a[11:3] == ADDR_CTRL[11:3])
        begin
            dec = {1'b1, 1'b0, 3'h0, 1'b0, a[2]};
        end
        else if (a[11:7] == ADDR_EQ_BASE[11:7])
        begin
            dec = {1'b1, 1'b1, a[6:4], a[3:2]};
        end
    endfunction : dec

    // ******************************************************
    // Evaluator shared by all equations in turn
    // ******************************************************
    logic [POOL_W-1:0]  pool;
    logic [NUM_IN-1:0]  ev_in;
    logic               ev_gate;
    logic               ev_rst;
    logic [TMR_W-1:0]   ev_tmr_nxt;
    logic               ev_out_nxt;
    logic               ev_lat_nxt;

    // Present outputs: lower equations were already refreshed this scan, higher ones still hold last scan
    assign pool = {{(POOL_W-POOL_LTN_LSB-NUM_EQ){1'b0}}, st_r.latch_n, st_r.latch, st_r.out, ext_sig};

    ple_eval u_eval
    (
        .pool      (pool),
        .cfg_in    (st_r.cfg_in[st_r.ptr]),
        .cfg_dly   (st_r.cfg_dly[st_r.ptr]),
        .cfg_rst   (st_r.cfg_rst[st_r.ptr]),
        .tmr       (st_r.tmr[st_r.ptr]),
        .tout      (st_r.out[st_r.ptr]),
        .latch     (st_r.latch[st_r.ptr]),
        .in_st     (ev_in),
        .gate      (ev_gate),
        .rst_act   (ev_rst),
        .tmr_nxt   (ev_tmr_nxt),
        .tout_nxt  (ev_out_nxt),
        .latch_nxt (ev_lat_nxt)
    );

    // ******************************************************
    // Next-state logic
    // ******************************************************
    logic [6:0]  wdec;
    logic [6:0]  rdec;
    logic [31:0] wmask;
    logic [31:0] old_w;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.scan_done = 1'b0;
        wdec  = dec(st_r.aw_addr);
        rdec  = dec(s_axi_araddr);
        wmask = '0;
        old_w = '0;

        // One equation per clock, ascending, wrapping after the last
        if (st_r.enable)
        begin
            st_nxt.in_st[st_r.ptr]   = ev_in;
            st_nxt.gate[st_r.ptr]    = ev_gate;
            st_nxt.rst_act[st_r.ptr] = ev_rst;
            st_nxt.tmr[st_r.ptr]     = ev_tmr_nxt;
            st_nxt.out[st_r.ptr]     = ev_out_nxt;
            st_nxt.latch[st_r.ptr]   = ev_lat_nxt;
            st_nxt.latch_n[st_r.ptr] = ~ev_lat_nxt;
            if (st_r.ptr == IDX_W'(NUM_EQ-1))
            begin
                st_nxt.ptr       = '0;
                st_nxt.scan_done = 1'b1;
                st_nxt.scan_cnt  = st_r.scan_cnt + 16'h0001;
            end
            else
            begin
                st_nxt.ptr = st_r.ptr + IDX_W'(1);
            end
        end

        // Address and data are taken in either order
        if (s_axi_awvalid && st_r.awrdy)
        begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wrdy)
        begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        // Write once both halves are held; byte enables protect the untouched lanes, save that a clear enable
        // takes data bit 0 if another written lane is nonzero
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
        begin
            for (int b = 0; b < 4; b++)
            begin
                wmask[b*8 +: 8] = {8{st_r.w_strb[b]}};
            end
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = wdec[6] ? RESP_OKAY : RESP_SLVERR;
            if (wdec[6] && !wdec[5] && wdec[1:0] == 2'h0)
            begin
                old_w = {31'h0, st_r.enable};
                st_nxt.enable = ((old_w & ~wmask) | (st_r.w_data & wmask)) != 32'h0 ?
                                ((old_w & ~wmask) | (st_r.w_data & wmask)) >> CTRL_EN_BIT != 32'h0 &&
                                st_r.w_data[CTRL_EN_BIT] | (st_r.enable & ~st_r.w_strb[0]) : 1'b0;
            end
            else if (wdec[6] && wdec[5])
            begin
                unique case (wdec[1:0])
                    WORD_INPUTS: st_nxt.cfg_in[wdec[4:2]] =
                        (st_r.cfg_in[wdec[4:2]] & ~wmask) | (st_r.w_data & wmask);
                    WORD_DELAYS: st_nxt.cfg_dly[wdec[4:2]] =
                        (st_r.cfg_dly[wdec[4:2]] & ~wmask) | (st_r.w_data & wmask);
                    WORD_RESET:  st_nxt.cfg_rst[wdec[4:2]] =
                        (st_r.cfg_rst[wdec[4:2]] & ~wmask) | (st_r.w_data & wmask);
                    WORD_STATUS: st_nxt.bresp = RESP_OKAY;                          // Read-only word
                endcase
            end
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end

        // Reads answer one cycle after the address is taken
        if (s_axi_arvalid && st_r.arrdy)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = rdec[6] ? RESP_OKAY : RESP_SLVERR;
            st_nxt.rdata  = 32'h0;
            if (rdec[6] && !rdec[5])
            begin
                st_nxt.rdata = rdec[0] ? {16'h0, st_r.scan_cnt} : {31'h0, st_r.enable};
            end
            else if (rdec[6])
            begin
                unique case (rdec[1:0])
                    WORD_INPUTS: st_nxt.rdata = st_r.cfg_in[rdec[4:2]];
                    WORD_DELAYS: st_nxt.rdata = st_r.cfg_dly[rdec[4:2]];
                    WORD_RESET:  st_nxt.rdata = st_r.cfg_rst[rdec[4:2]];
                    WORD_STATUS: st_nxt.rdata = {23'h0,
                                                 st_r.rst_act[rdec[4:2]],
                                                 st_r.latch_n[rdec[4:2]],
                                                 st_r.latch[rdec[4:2]],
                                                 st_r.out[rdec[4:2]],
                                                 st_r.gate[rdec[4:2]],
                                                 st_r.in_st[rdec[4:2]]};
                endcase
            end
        end
        else if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end

        // Ready flags are registered so the ports come straight from flops
        st_nxt.awrdy = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wrdy  = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.arrdy = !st_nxt.rvalid;
    end

    // ******************************************************
    // State register
    // ******************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r         <= '0;
            st_r.enable  <= EN_RST;
            st_r.cfg_in  <= {NUM_EQ{CFG_IN_RST}};
            st_r.cfg_dly <= {NUM_EQ{CFG_DLY_RST}};
            st_r.cfg_rst <= {NUM_EQ{CFG_RST_RST}};
            st_r.latch_n <= '1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = st_r.awrdy;
    assign s_axi_wready  = st_r.wrdy;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arrdy;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign eq_out        = st_r.out;
    assign eq_latched    = st_r.latch;
    assign eq_latched_n  = st_r.latch_n;
    assign scan_done     = st_r.scan_done;

    // ******************************************************
    // Assertions
    // ******************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_PTR_WRAP: assert property (st_r.enable && st_r.ptr == IDX_W'(NUM_EQ-1) |=> st_r.ptr == '0 && scan_done)
        else $error("pointer did not wrap after last equation");
    AST_PTR_STEP: assert property (st_r.enable && st_r.ptr != IDX_W'(NUM_EQ-1) |=> st_r.ptr == $past(st_r.ptr) + IDX_W'(1))
        else $error("pointer did not advance by one");
    AST_LATCH_INV: assert property (eq_latched_n == ~eq_latched)
        else $error("inverted latch output mismatch");
    AST_RESET_WINS: assert property (st_r.enable && ev_rst |=> !eq_latched[$past(st_r.ptr)])
        else $error("latch not cleared by active reset");
    AST_LATCH_SET: assert property (st_r.enable && ev_out_nxt && !ev_rst |=> eq_latched[$past(st_r.ptr)])
        else $error("latch not set by output");
    AST_LATCH_HOLD: assert property (st_r.enable && !ev_rst && st_r.latch[st_r.ptr] |=> eq_latched[$past(st_r.ptr)])
        else $error("latch dropped without reset");
    AST_ZERO_ON: assert property (st_r.enable && ev_gate && st_r.cfg_dly[st_r.ptr][DLY_ON_LSB +: TMR_W] == '0
                                  |=> eq_out[$past(st_r.ptr)])
        else $error("zero on delay did not pass gate at once");
    AST_EQ0_STABLE: assert property (st_r.ptr != '0 |=> $stable(eq_out[0]))
        else $error("equation 0 changed outside its slot");
    AST_AND_OP: assert property (st_r.cfg_in[st_r.ptr][IN_OP_LSB +: 3] == PLE_OP_AND |-> ev_gate == &ev_in)
        else $error("AND gate result wrong");
    AST_OFF_DELAY: assert property (st_r.enable && !ev_gate && st_r.out[st_r.ptr]
                                    && st_r.cfg_dly[st_r.ptr][DLY_OFF_LSB +: TMR_W] > 16'h0001
                                    && st_r.tmr[st_r.ptr] == '0 |=> eq_out[$past(st_r.ptr)])
        else $error("off delay expired too early");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");

    COV_SCAN: cover property (scan_done ##8 scan_done);
    COV_RESET_WINS: cover property (st_r.enable && ev_rst && ev_out_nxt);
    COV_WRITE: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
    COV_DELAYED: cover property (st_r.enable && ev_gate != st_r.out[st_r.ptr] && ev_tmr_nxt != '0);

endmodule : ple_top
`default_nettype wire

// file: sim/ple_sig_src.sv
// Behavioural source of the assignable internal signals feeding the equation bank
`timescale 1ns/100ps
`default_nettype none
module ple_sig_src
(
    input  wire logic        aclk,
    input  wire logic [31:0] want,
    output logic      [31:0] ext_sig
);
    // Passed straight through: the bench changes want right after an edge, so the pool
    // sees a new value from the very next slot and a mid-scan change reaches only the later slots
    assign ext_sig = want;
endmodule : ple_sig_src
`default_nettype wire

// file: sim/ple_top_test.sv
// Self-checking testbench of the logic equation bank
`timescale 1ns/100ps
`default_nettype none
module ple_top_test;
    import ple_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid, scan_done;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, want, ext_sig, d;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  eq_out, eq_lat, eq_lat_n;
    int          n_errors = 0;
    int          n_checks = 0;

    ple_sig_src u_ple_sig_src (.aclk(aclk), .want(want), .ext_sig(ext_sig));
    // Response ready held high throughout, which the bus allows
    ple_top u_ple_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ext_sig(ext_sig),
        .eq_out(eq_out), .eq_latched(eq_lat), .eq_latched_n(eq_lat_n), .scan_done(scan_done));

    // ************************************************
    // Reporting and bus tasks
    // ************************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic hang();
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        give_verdict();
    endtask : hang

    // Address and data offered together, each dropped at its own handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid && n < 64);
        if (n >= 64) hang();
        resp = bresp;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid && n < 64);
        if (n >= 64) hang();
        d    = rdata;
        resp = rresp;
    endtask : rd

    // Returns at the edge that samples the end-of-scan pulse
    task automatic scans(input int k);
        int n;
        repeat (k)
        begin
            n = 0;
            do @(posedge aclk); while (!scan_done && ++n < 32);
            if (n >= 32) hang();
        end
    endtask : scans

    function automatic logic [31:0] cfg(input int op, input logic [3:0] inv, input logic [5:0] s);
        return {1'b0, op[2:0], inv, s + 6'd3, s + 6'd2, s + 6'd1, s};
    endfunction : cfg

    function automatic logic gate(input int op, input logic [3:0] v);
        case (op)
            1: return |v;
            2: return ~&v;
            3: return ~|v;
            4: return ^v;
            5: return ~^v;
            default: return &v;
        endcase
    endfunction : gate

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_regs();
        rd(ADDR_CTRL);
        chk(d, 32'h1);
        rd(12'h108);
        chk(d, CFG_RST_RST);
        rd(12'h800);
        chk({resp, d}, {RESP_SLVERR, 32'h0});
        wr(12'h800, 32'h1);
        chk(resp, RESP_SLVERR);
        $display("test regs done");
    endtask : t_regs

    // Every operator on two input patterns, inputs 0..3 with a mixed inversion
    task automatic t_gates();
        logic [3:0] e;
        for (int p = 0; p < 2; p++)
            for (int op = 0; op < 6; op++)
            begin
                e = p ? 4'b1010 : 4'b0011;
                wr(ADDR_EQ_BASE, cfg(op, 4'h5, 6'd0));
                want <= {28'h0, e};
                scans(2);
                chk(eq_out[0], gate(op, e ^ 4'h5));
            end
        rd(12'h10c);
        chk(d[4:0], {gate(5, 4'hf), 4'hf});
        $display("test gates done");
    endtask : t_gates

    // Equation 1 follows 0 in the same scan, 3 sees 4 one scan late
    task automatic t_cascade();
        wr(12'h100, cfg(0, 4'h0, 6'd5) & 32'hf000_0000 | {4{6'd5}});
        wr(12'h110, {8'h0, {4{6'd32}}});
        wr(12'h130, {8'h0, {4{6'd36}}});
        wr(12'h140, {8'h0, {4{6'd5}}});
        want <= 32'h0;
        scans(2);
        // Source rises just after equation 0's slot: 4 updates in this scan, 3 read it too early
        want <= 32'h20;
        scans(1);
        chk(eq_out[4:3], 2'b10);
        chk(eq_out[1:0], 2'b00);
        scans(1);
        chk(eq_out[1:0], 2'b11);
        chk({eq_lat[1], eq_lat_n[1]}, 2'b10);
        chk(eq_out[3], 1'b1);
        $display("test cascade done");
    endtask : t_cascade

    task automatic t_latch();
        wr(12'h118, 32'h6);
        want <= 32'h60;
        scans(2);
        chk({eq_out[1], eq_lat[1]}, 2'b10);
        want <= 32'h20;
        scans(2);
        chk(eq_lat[1], 1'b1);
        want <= 32'h0;
        scans(2);
        chk({eq_out[1], eq_lat[1], eq_lat_n[1]}, 3'b010);
        wr(12'h118, 32'h106);
        scans(2);
        chk(eq_lat[1], 1'b0);
        $display("test latch done");
    endtask : t_latch

    // On delay of three scans, off delay of two
    task automatic t_delay();
        wr(12'h144, {16'd2, 16'd3});
        scans(1);
        want <= 32'h20;
        scans(2);
        chk(eq_out[4], 1'b0);
        scans(1);
        chk(eq_out[4], 1'b1);
        want <= 32'h0;
        scans(1);
        chk(eq_out[4], 1'b1);
        scans(1);
        chk(eq_out[4], 1'b0);
        $display("test delay done");
    endtask : t_delay

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Reset for two cycles, then the scenarios in order
    initial
    begin
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, want} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({eq_out, eq_lat, eq_lat_n}, 24'h0000ff);
        t_regs();
        t_gates();
        t_cascade();
        t_latch();
        t_delay();
        give_verdict();
    end
endmodule : ple_top_test
`default_nettype wire
